// >>> pkg/arc_pkg.sv
// arc_pkg: shared constants, carriers and tables of the converter control
// assumes a 100 MHz system clock; all times are typical figures in microseconds
package arc_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int US_CYC = 1000 / CLK_PERIOD_NS;

  localparam int MIN_RES = 12;
  localparam int MAX_RES = 24;
  localparam int TEMP_RES = 18;
  localparam int CALC_US = 1380;

  localparam logic [7:0] OFS_SETUP = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_GAIN = 8'h18;
  localparam logic [7:0] OFS_SHIFT = 8'h1c;
  localparam logic [7:0] OFS_CONV = 8'h20;

  localparam logic [15:0] SETUP_RST = 16'h0000;
  localparam int CTRL_MEASURE = 0;
  localparam int IRQ_MEAS = 0;
  localparam int IRQ_CONV = 1;
  localparam int IRQ_CFG = 2;
  localparam int IRQ_W = 3;

  typedef struct packed {
    logic shift_en;
    logic [2:0] offset;
    logic absv_en;
    logic [3:0] res_code;
    logic polarity;
    logic [2:0] second_stage_gain_field;
    logic [2:0] first_stage_gain_field;
  } arc_setup_t;

  typedef struct packed {
    logic [1:0] adc_gain;
    logic [6:0] amp1;
    logic [4:0] amp2_tenths;
    logic [12:0] total_tenths;
    logic [12:0] shift_centi;
    logic cfg_err;
  } arc_gain_t;

  typedef enum logic [2:0] {
    ARC_IDLE,
    ARC_AZ_SENSOR,
    ARC_SENSOR,
    ARC_AZ_TEMP,
    ARC_TEMP,
    ARC_CALC
  } arc_phase_t;

  // codes above 12 saturate at the top resolution
  function automatic logic [4:0] res_bits(input logic [3:0] code);
    res_bits = (code > 4'hc) ? 5'(MAX_RES) : 5'(MIN_RES + int'(code));
  endfunction : res_bits

  function automatic logic [12:0] conv_us(input logic [4:0] res);
    case (res)
      5'h0c: conv_us = 13'd140;
      5'h0d: conv_us = 13'd185;
      5'h0e: conv_us = 13'd250;
      5'h0f: conv_us = 13'd335;
      5'h10: conv_us = 13'd470;
      5'h11: conv_us = 13'd640;
      5'h12: conv_us = 13'd890;
      5'h13: conv_us = 13'd1250;
      5'h14: conv_us = 13'd1760;
      5'h15: conv_us = 13'd2460;
      5'h16: conv_us = 13'd3480;
      5'h17: conv_us = 13'd4890;
      default: conv_us = 13'd6940;
    endcase
  endfunction : conv_us

  function automatic logic [6:0] amp1_gain(input logic [2:0] code);
    case (code)
      3'h0: amp1_gain = 7'd6;
      3'h1: amp1_gain = 7'd12;
      3'h2: amp1_gain = 7'd20;
      3'h3: amp1_gain = 7'd30;
      3'h4: amp1_gain = 7'd40;
      3'h5: amp1_gain = 7'd60;
      3'h6: amp1_gain = 7'd80;
      default: amp1_gain = 7'd120;
    endcase
  endfunction : amp1_gain

  // second stage in tenths: 1.1 to 1.8
  function automatic logic [4:0] amp2_tenths(input logic [2:0] code);
    amp2_tenths = 5'(11 + int'(code));
  endfunction : amp2_tenths

  // shift in hundredths of a percent of full scale
  function automatic logic [12:0] shift_centi(input logic [2:0] code);
    case (code)
      3'h0: shift_centi = 13'd0;
      3'h1: shift_centi = 13'd675;
      3'h2: shift_centi = 13'd1250;
      3'h3: shift_centi = 13'd1925;
      3'h4: shift_centi = 13'd2500;
      3'h5: shift_centi = 13'd3175;
      3'h6: shift_centi = 13'd3850;
      default: shift_centi = 13'd4325;
    endcase
  endfunction : shift_centi

endpackage : arc_pkg

// >>> verilog/arc_conv_timer.sv
// arc_conv_timer: down counter timing one conversion or the calculation step
// assumes a synchronous start pulse and a load of at least one cycle
`timescale 1ns/1ns
module arc_conv_timer (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [23:0] load_i,
  output logic busy_o,
  output logic done_o
);

  logic [23:0] cnt_q;
  logic busy_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 24'h000000;
      busy_q <= 1'b0;
    end else if (start_i) begin
      cnt_q <= load_i;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 24'h000001;
      busy_q <= (cnt_q != 24'h000001);
    end
  end

  assign busy_o = busy_q;
  assign done_o = busy_q && (cnt_q == 24'h000001);

endmodule : arc_conv_timer

// >>> verilog/arc_gain_decode.sv
// arc_gain_decode: registered decode of the setup word into gain and shift
// assumes the setup word is stable while a measurement runs
`timescale 1ns/1ns
module arc_gain_decode (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire arc_pkg::arc_setup_t setup_i,
  output arc_pkg::arc_gain_t gain_o
);

  arc_pkg::arc_gain_t gain_q;
  logic [1:0] adc_gain;
  int total;

  assign adc_gain = setup_i.shift_en ? 2'h2 : 2'h1;
  assign total = int'(arc_pkg::amp1_gain(setup_i.first_stage_gain_field))
    * int'(arc_pkg::amp2_tenths(setup_i.second_stage_gain_field)) * int'(adc_gain);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gain_q <= '0;
    end else begin
      gain_q.adc_gain <= adc_gain;
      gain_q.amp1 <= arc_pkg::amp1_gain(setup_i.first_stage_gain_field);
      gain_q.amp2_tenths <= arc_pkg::amp2_tenths(setup_i.second_stage_gain_field);
      gain_q.total_tenths <= 13'(total);
      // shift only with the enable set; offset field picks the amount
      gain_q.shift_centi <= setup_i.shift_en ? arc_pkg::shift_centi(setup_i.offset) : 13'h0000;
      gain_q.cfg_err <= !setup_i.shift_en && (setup_i.offset != 3'h0);
    end
  end

  assign gain_o = gain_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_shift_gate: assert property (!setup_i.shift_en |=> gain_o.shift_centi == 13'h0000)
    else $error("shift present without enable");
  a_offset_field: assert property (setup_i.shift_en && setup_i.offset == 3'h4 |=> gain_o.shift_centi == 13'd2500)
    else $error("offset field 100 not 25 percent");
  a_adc_gain_two: assert property (setup_i.shift_en && setup_i.offset == 3'h0 |=> gain_o.adc_gain == 2'h2)
    else $error("gain two missing at zero offset");
  a_shift_table_ends: assert property (setup_i.shift_en && setup_i.offset == 3'h7 |=> gain_o.shift_centi == 13'd4325)
    else $error("top offset code wrong");
  a_total_gain: assert property (setup_i == arc_pkg::arc_setup_t'(16'h8000) |=> gain_o.total_tenths == 13'd132)
    else $error("total gain with shift wrong");
  a_stage_tables: assert property (setup_i == arc_pkg::arc_setup_t'(16'h003f) |=> gain_o.total_tenths == 13'd2160)
    else $error("stage gain tables wrong");

endmodule : arc_gain_decode

// >>> verilog/arc_top.sv
// arc_top: converter setup register, measurement sequencer, end-of-conversion pin
// assumes an Avalon-MM master on sys_clk_i and an asynchronous active-low reset
`timescale 1ns/1ns
module arc_top #(
  parameter int US_CYCLES = arc_pkg::US_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  output logic eoc_o,
  output arc_pkg::arc_setup_t afe_setup_o,
  output logic [4:0] adc_res_o
);

  logic rst_b_meta_q;
  logic rst_b_q;

  // release is synchronised; assertion stays asynchronous
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_b_meta_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_b_meta_q <= 1'b1;
      rst_b_q <= rst_b_meta_q;
    end
  end

  // bus slave: one wait cycle, then the answer
  logic req;
  logic ack_q;
  logic wr_en;
  logic rd_take;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_en = avs_write_i & ack_q;
  assign rd_take = avs_read_i & ~ack_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // every input passed in, so continuous uses stay sensitive to the bus
  function automatic logic hit(input logic en, input logic [7:0] addr, input logic [7:0] ofs);
    hit = en && (addr == ofs);
  endfunction : hit

  // setup word as software sees it
  arc_pkg::arc_setup_t setup_q;
  arc_pkg::arc_setup_t wr_setup;

  assign wr_setup = arc_pkg::arc_setup_t'(avs_writedata_i[15:0]);

  always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      setup_q <= arc_pkg::arc_setup_t'(arc_pkg::SETUP_RST);
    end else if (hit(wr_en, avs_address_i, arc_pkg::OFS_SETUP)) begin
      setup_q <= wr_setup;
    end
  end

  // measurement sequencer
  arc_pkg::arc_phase_t st_q;
  arc_pkg::arc_phase_t st_d;
  arc_pkg::arc_setup_t act_q;
  logic [4:0] res_q;
  logic meas_cmd;
  logic conv_go;
  int load_us;
  logic [23:0] load_cyc;
  logic tmr_done;
  logic tmr_busy;
  logic conv_done;
  logic meas_done;

  assign meas_cmd = hit(wr_en, avs_address_i, arc_pkg::OFS_CTRL) && avs_writedata_i[arc_pkg::CTRL_MEASURE];

  // the active word is frozen while a measurement runs
  always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      act_q <= arc_pkg::arc_setup_t'(arc_pkg::SETUP_RST);
      res_q <= 5'(arc_pkg::MIN_RES);
    end else if (st_q == arc_pkg::ARC_IDLE) begin
      act_q <= setup_q;
      res_q <= arc_pkg::res_bits(setup_q.res_code);
    end
  end

  always_comb begin
    st_d = st_q;
    conv_go = 1'b0;
    load_us = 0;
    case (st_q)
      arc_pkg::ARC_IDLE: begin
        if (meas_cmd) begin
          st_d = arc_pkg::ARC_AZ_SENSOR;
          conv_go = 1'b1;
          load_us = int'(arc_pkg::conv_us(res_q));
        end
      end
      arc_pkg::ARC_AZ_SENSOR: begin
        if (tmr_done) begin
          st_d = arc_pkg::ARC_SENSOR;
          conv_go = 1'b1;
          load_us = int'(arc_pkg::conv_us(res_q));
        end
      end
      arc_pkg::ARC_SENSOR: begin
        if (tmr_done) begin
          st_d = arc_pkg::ARC_AZ_TEMP;
          conv_go = 1'b1;
          load_us = int'(arc_pkg::conv_us(5'(arc_pkg::TEMP_RES)));
        end
      end
      arc_pkg::ARC_AZ_TEMP: begin
        if (tmr_done) begin
          st_d = arc_pkg::ARC_TEMP;
          conv_go = 1'b1;
          load_us = int'(arc_pkg::conv_us(5'(arc_pkg::TEMP_RES)));
        end
      end
      arc_pkg::ARC_TEMP: begin
        if (tmr_done) begin
          // correction step before the result counts as ready
          st_d = arc_pkg::ARC_CALC;
          conv_go = 1'b1;
          load_us = arc_pkg::CALC_US;
        end
      end
      arc_pkg::ARC_CALC: begin
        if (tmr_done) begin
          st_d = arc_pkg::ARC_IDLE;
        end
      end
      default: begin
        st_d = arc_pkg::ARC_IDLE;
      end
    endcase
  end

  assign load_cyc = 24'(load_us * US_CYCLES);

  always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      st_q <= arc_pkg::ARC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  arc_conv_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_q),
    .start_i(conv_go),
    .load_i(load_cyc),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  assign conv_done = tmr_done && (st_q != arc_pkg::ARC_CALC) && (st_q != arc_pkg::ARC_IDLE);
  assign meas_done = tmr_done && (st_q == arc_pkg::ARC_CALC);

  // pin idles high; low span is exactly one measurement
  logic eoc_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      eoc_q <= 1'b1;
    end else if (st_q == arc_pkg::ARC_IDLE && meas_cmd) begin
      eoc_q <= 1'b0;
    end else if (meas_done) begin
      eoc_q <= 1'b1;
    end
  end

  assign eoc_o = eoc_q;
  assign afe_setup_o = act_q;
  assign adc_res_o = res_q;

  // gain and shift of the active word
  arc_pkg::arc_gain_t gain;

  arc_gain_decode u_decode (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_q),
    .setup_i(act_q),
    .gain_o(gain)
  );

  // interrupts: set wins over a clear in the same cycle
  logic [arc_pkg::IRQ_W-1:0] irq_st_q;
  logic [arc_pkg::IRQ_W-1:0] irq_en_q;
  logic [arc_pkg::IRQ_W-1:0] irq_set;
  logic [arc_pkg::IRQ_W-1:0] irq_clr;

  // bad setup is only flagged; the far side must avoid it
  assign irq_set[arc_pkg::IRQ_MEAS] = meas_done;
  assign irq_set[arc_pkg::IRQ_CONV] = conv_done;
  assign irq_set[arc_pkg::IRQ_CFG] = hit(wr_en, avs_address_i, arc_pkg::OFS_SETUP) && !wr_setup.shift_en
    && (wr_setup.offset != 3'h0);
  assign irq_clr = hit(wr_en, avs_address_i, arc_pkg::OFS_IRQ_CLR) ? avs_writedata_i[arc_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= irq_set | (irq_st_q & ~irq_clr);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      irq_en_q <= '0;
    end else if (hit(wr_en, avs_address_i, arc_pkg::OFS_IRQ_EN)) begin
      irq_en_q <= avs_writedata_i[arc_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_st_q & irq_en_q);

  // read mux; unmapped and write-only offsets read zero
  logic [31:0] rd_d;
  logic [31:0] rdata_q;

  always_comb begin
    rd_d = 32'h00000000;
    case (avs_address_i)
      arc_pkg::OFS_SETUP: rd_d[15:0] = setup_q;
      arc_pkg::OFS_STATUS: rd_d[6:0] = {st_q, 1'b0, gain.cfg_err, eoc_q, tmr_busy};
      arc_pkg::OFS_IRQ_ST: rd_d[arc_pkg::IRQ_W-1:0] = irq_st_q;
      arc_pkg::OFS_IRQ_EN: rd_d[arc_pkg::IRQ_W-1:0] = irq_en_q;
      arc_pkg::OFS_GAIN: rd_d[17:0] = {gain.adc_gain, 3'h0, gain.total_tenths};
      arc_pkg::OFS_SHIFT: rd_d[12:0] = gain.shift_centi;
      arc_pkg::OFS_CONV: rd_d[20:0] = {res_q, 3'h0, arc_pkg::conv_us(res_q)};
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      rdata_q <= 32'h00000000;
    end else if (rd_take) begin
      rdata_q <= rd_d;
    end
  end

  assign avs_readdata_o = rdata_q;

  // helper: cycles since the last timer start
  logic [23:0] cyc_h;

  always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      cyc_h <= 24'h000000;
    end else if (conv_go) begin
      cyc_h <= 24'h000001;
    end else begin
      cyc_h <= cyc_h + 24'h000001;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_q);

  sequence s_meas_start;
    st_q == arc_pkg::ARC_IDLE && meas_cmd;
  endsequence

  sequence s_sensor_end;
    st_q == arc_pkg::ARC_SENSOR && tmr_done;
  endsequence

  sequence s_az_sensor_end;
    st_q == arc_pkg::ARC_AZ_SENSOR && tmr_done;
  endsequence

  sequence s_temp_az_end;
    st_q == arc_pkg::ARC_AZ_TEMP && tmr_done;
  endsequence

  sequence s_meas_end;
    st_q == arc_pkg::ARC_CALC && tmr_done;
  endsequence

  a_res_range: assert property (res_q >= 5'd12 && res_q <= 5'd24)
    else $error("resolution outside 12 to 24");
  a_res_code_map: assert property (st_q == arc_pkg::ARC_IDLE && setup_q.res_code == 4'h5 |=> res_q == 5'd17)
    else $error("resolution code not mapped");
  a_conv_time_low: assert property (s_sensor_end and res_q == 5'd12 |-> cyc_h == 24'(140 * US_CYCLES))
    else $error("12-bit conversion time wrong");
  a_conv_time_high: assert property (s_sensor_end and res_q == 5'd24 |-> cyc_h == 24'(6940 * US_CYCLES))
    else $error("24-bit conversion time wrong");
  a_meas_start: assert property (s_meas_start |=> st_q == arc_pkg::ARC_AZ_SENSOR && !eoc_o)
    else $error("measure did not start auto-zero");
  a_meas_order: assert property (s_sensor_end |=> st_q == arc_pkg::ARC_AZ_TEMP)
    else $error("temperature auto-zero not next");
  a_temp_res: assert property (st_q == arc_pkg::ARC_TEMP && tmr_done |-> cyc_h == 24'(890 * US_CYCLES))
    else $error("temperature not at 18 bits");
  a_eoc_fall: assert property ($fell(eoc_o) |-> st_q == arc_pkg::ARC_AZ_SENSOR && $past(st_q) == arc_pkg::ARC_IDLE)
    else $error("end-of-conversion fell outside start");
  a_eoc_frame: assert property (eoc_o == (st_q == arc_pkg::ARC_IDLE))
    else $error("end-of-conversion not framing measurement");

  // later phases; each counted from its own timer start
  a_sensor_next: assert property (s_az_sensor_end |=> st_q == arc_pkg::ARC_SENSOR)
    else $error("sensor conversion not after auto-zero");
  a_temp_az_res: assert property (s_temp_az_end |-> cyc_h == 24'(890 * US_CYCLES))
    else $error("temperature auto-zero not at 18 bits");
  a_calc_len: assert property (s_meas_end |-> cyc_h == 24'(arc_pkg::CALC_US * US_CYCLES))
    else $error("calculation step length wrong");
  a_eoc_rise: assert property (s_meas_end |=> st_q == arc_pkg::ARC_IDLE && eoc_o)
    else $error("end-of-conversion did not rise at end");
  a_act_frozen: assert property (st_q != arc_pkg::ARC_IDLE |=> $stable(act_q))
    else $error("active setup moved during measurement");
  a_res_saturate: assert property (st_q == arc_pkg::ARC_IDLE && setup_q.res_code > 4'hc |=> res_q == 5'd24)
    else $error("high resolution codes not at 24 bits");

endmodule : arc_top

// >>> tb/arc_afe_model.sv
// arc_afe_model: front-end stand-in that times each end-of-conversion frame
// assumes eoc_i idles high and one clock domain; reports frame length in cycles
`timescale 1ns/1ns
module arc_afe_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic eoc_i,
  input wire arc_pkg::arc_setup_t setup_i,
  output logic [31:0] low_cycles_o,
  output logic frame_done_o,
  output logic setup_moved_o
);
  logic eoc_q;
  arc_pkg::arc_setup_t setup_q;

  // the analog side must see one frozen setup for the whole frame
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      eoc_q <= 1'b1;
      low_cycles_o <= 32'h0;
      frame_done_o <= 1'b0;
      setup_moved_o <= 1'b0;
      setup_q <= '0;
    end else begin
      eoc_q <= eoc_i;
      frame_done_o <= eoc_i && !eoc_q;
      if (eoc_q && !eoc_i) begin
        low_cycles_o <= 32'h1;
        setup_q <= setup_i;
        setup_moved_o <= 1'b0;
      end else if (!eoc_i) begin
        low_cycles_o <= low_cycles_o + 32'h1;
        if (setup_i !== setup_q) begin
          setup_moved_o <= 1'b1;
        end
      end
    end
  end
endmodule : arc_afe_model

// >>> tb/tb_adc_resolution_offset_control.sv
// tb_adc_resolution_offset_control: self-checking bench of arc_top over Avalon-MM
// assumes US_CYCLES of 1, so one microsecond of typical time is one clock cycle
`timescale 1ns/1ns
module tb_adc_resolution_offset_control;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic irq_o;
  logic eoc_o;
  logic [4:0] adc_res_o;
  arc_pkg::arc_setup_t afe_setup_o;
  logic frame_done;
  logic setup_moved;
  logic [31:0] low_cycles;
  logic [31:0] lfsr = 32'h00007d3e;
  logic [31:0] e;
  int n_errors = 0;
  int compares = 0;
  logic [31:0] rq[$];
  logic [31:0] mq[$];
  logic [6:0] amp1_t[8] = '{7'h06, 7'h0c, 7'h14, 7'h1e, 7'h28, 7'h3c, 7'h50, 7'h78};
  logic [12:0] shift_t[8] = '{13'h0, 13'h2a3, 13'h4e2, 13'h785, 13'h9c4, 13'hc67, 13'hf0a, 13'h10e5};
  logic [12:0] conv_t[13] = '{13'h8c, 13'hb9, 13'hfa, 13'h14f, 13'h1d6, 13'h280, 13'h37a,
                              13'h4e2, 13'h6e0, 13'h99c, 13'hd98, 13'h131a, 13'h1b1c};

  always #5 sys_clk_i = ~sys_clk_i;

  arc_top #(.US_CYCLES(1)) u_dut (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o),
    .eoc_o(eoc_o),
    .afe_setup_o(afe_setup_o),
    .adc_res_o(adc_res_o)
  );

  arc_afe_model u_afe (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .eoc_i(eoc_o),
    .setup_i(afe_setup_o),
    .low_cycles_o(low_cycles),
    .frame_done_o(frame_done),
    .setup_moved_o(setup_moved)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // waitrequest is sampled just before the edge, so the edge itself never races
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic w;
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    do begin
      @(negedge sys_clk_i);
      w = avs_waitrequest_o;
      @(posedge sys_clk_i);
      n++;
    end while (w !== 1'b0 && n < 50);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (w !== 1'b0) begin
      n_errors++;
      end_sim();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic idle();
    repeat (4) @(negedge sys_clk_i);
  endtask : idle

  task automatic cfg(input logic [15:0] s);
    int r;
    int g;
    r = (s[10:7] > 4'hc) ? 24 : 12 + s[10:7];
    g = s[15] ? 2 : 1;
    wr(arc_pkg::OFS_SETUP, {16'h0, s});
    idle();
    check({16'h0, afe_setup_o}, {16'h0, s});
    check({27'h0, adc_res_o}, 32'(r));
    rd(arc_pkg::OFS_CONV, {11'h0, 5'(r), 3'h0, conv_t[r-12]});
    rd(arc_pkg::OFS_GAIN, {14'h0, 2'(g), 3'h0, 13'(amp1_t[s[2:0]] * (11 + s[5:3]) * g)});
    rd(arc_pkg::OFS_SHIFT, {19'h0, s[15] ? shift_t[s[14:12]] : 13'h0});
  endtask : cfg

  // a second start and a setup change mid-frame must leave the frame untouched
  task automatic meas(input int t, input logic [15:0] s);
    int n;
    n = 0;
    mq.push_back(32'(2 * t + 3160));
    wr(arc_pkg::OFS_CTRL, 32'h1);
    wr(arc_pkg::OFS_CTRL, 32'h1);
    rd(arc_pkg::OFS_STATUS, 32'h11);
    wr(arc_pkg::OFS_SETUP, {16'h0, s ^ 16'h0007});
    while (eoc_o !== 1'b1 && n < 20000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 20000) begin
      n_errors++;
      end_sim();
    end
    idle();
    check({31'h0, setup_moved}, 32'h0);
    check({31'h0, irq_o}, 32'h1);
    rd(arc_pkg::OFS_IRQ_ST, 32'h3);
    wr(arc_pkg::OFS_IRQ_CLR, 32'h7);
    idle();
    check({31'h0, irq_o}, 32'h0);
  endtask : meas

  // results are compared as they appear, oldest expectation first
  always @(negedge sys_clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      check(avs_readdata_o, rq.pop_front());
    end
    if (frame_done === 1'b1) begin
      e = mq.pop_front();
      check({31'h0, (low_cycles + 32'h2 >= e) && (low_cycles <= e + 32'h2)}, 32'h1);
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rd(arc_pkg::OFS_SETUP, 32'h0);
    rd(arc_pkg::OFS_IRQ_EN, 32'h0);
    rd(arc_pkg::OFS_CONV, {11'h0, 5'h0c, 3'h0, 13'h8c});
    wr(8'h24, 32'hffffffff);
    rd(8'h24, 32'h0);
    for (int i = 0; i < 16; i++) begin
      cfg({5'h00, 4'(i), 7'(rnd())});
    end
    for (int i = 0; i < 8; i++) begin
      cfg({1'b1, 3'(i), 1'(rnd()), 4'h4, 7'(rnd())});
    end
    cfg(16'h3000);
    check({31'h0, irq_o}, 32'h0);
    rd(arc_pkg::OFS_IRQ_ST, 32'h4);
    rd(arc_pkg::OFS_STATUS, 32'h6);
    wr(arc_pkg::OFS_IRQ_EN, 32'h4);
    idle();
    check({31'h0, irq_o}, 32'h1);
    cfg(16'h0000);
    wr(arc_pkg::OFS_IRQ_CLR, 32'h7);
    idle();
    check({31'h0, irq_o}, 32'h0);
    wr(arc_pkg::OFS_IRQ_EN, 32'h1);
    meas(140, 16'h0000);
    cfg({5'h00, 4'hc, 7'h00});
    meas(6940, {5'h00, 4'hc, 7'h00});
    end_sim();
  end
endmodule : tb_adc_resolution_offset_control
